// [rtl/frontend_ctrl_regs.v]
`timescale 1ns/1ps
`include "frontend_regs_map.vh"
// control register bank of the acquisition front end
// six byte registers reached over a mode 0 serial port
// two byte pairs form the drop count and the current threshold
// gain and power bytes drive the analog front end directly
// hazard: pairs are not shadowed, the host writes both bytes
// every output is a flop so the analog side never sees a glitch
module frontend_ctrl_regs (
  input wire mclk_in,
  input wire rstn_in,
  input wire sclk_in,
  input wire csn_in,
  input wire mosi_in,
  output reg miso_out,
  output reg miso_oen_out,
  output reg [15:0] sample_drop_interval_out,
  output reg [15:0] current_threshold_out,
  output reg [1:0] gain_current_out,
  output reg [1:0] gain_voltage_out,
  output reg chop_clk_current_en_out,
  output reg chop_clk_voltage_en_out,
  output reg amp_current_en_out,
  output reg mod_current_en_out,
  output reg amp_voltage_en_out,
  output reg mod_voltage_en_out
);
  wire [6:0] addr;
  wire rd_req;
  wire wr_stb;
  wire [7:0] wr_data;
  wire miso_w;
  wire miso_oen_w;
  // one flop per register byte, reserved bits included
  reg [7:0] drop_hi_ff;
  reg [7:0] drop_lo_ff;
  reg [7:0] thr_hi_ff;
  reg [7:0] thr_lo_ff;
  reg [7:0] gain_ff;
  reg [7:0] pwr1_ff;
  reg [7:0] rd_data_ff;
  reg [7:0] nxt_rd_data;

  // used by both the gain and the power byte
  // merge writable bits, reserved ones keep their reset value
  function [7:0] merge;
    input [7:0] rst_val;
    input [7:0] mask;
    input [7:0] data;
    begin
      merge = (data & mask) | (rst_val & ~mask);
    end
  endfunction

  // serial framing and pin synchronisers live in the shifter
  spi_frame_shifter u_spi (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .sclk_in(sclk_in),
    .csn_in(csn_in),
    .mosi_in(mosi_in),
    .rd_data_in(rd_data_ff),
    .addr_out(addr),
    .rd_req_out(rd_req),
    .wr_stb_out(wr_stb),
    .wr_data_out(wr_data),
    .miso_out(miso_w),
    .miso_oen_out(miso_oen_w)
  );

  // register writes, one strobe per write frame from the shifter
  // limitation: a half written pair shows through until both bytes land
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      drop_hi_ff <= `RST_ZERO;
      drop_lo_ff <= `RST_ZERO;
      thr_hi_ff <= `RST_ZERO;
      thr_lo_ff <= `RST_ZERO;
      gain_ff <= `RST_GAIN;
      pwr1_ff <= `RST_PWR1;
    end else if (wr_stb) begin
      case (addr)
        `ADDR_DROP_HI: drop_hi_ff <= wr_data;
        `ADDR_DROP_LO: drop_lo_ff <= wr_data;
        `ADDR_THR_HI: thr_hi_ff <= wr_data;
        `ADDR_THR_LO: thr_lo_ff <= wr_data;
        `ADDR_GAIN: gain_ff <= merge(`RST_GAIN, `GAIN_WMASK, wr_data);
        `ADDR_PWR1: pwr1_ff <= merge(`RST_PWR1, `PWR1_WMASK, wr_data);
        // unmapped addresses fall through untouched
        default: ;
      endcase
    end
  end

  // sampled once at the address phase of a read frame
  // read mux, unmapped addresses read zero
  always @* begin
    case (addr)
      `ADDR_DROP_HI: nxt_rd_data = drop_hi_ff;
      `ADDR_DROP_LO: nxt_rd_data = drop_lo_ff;
      `ADDR_THR_HI: nxt_rd_data = thr_hi_ff;
      `ADDR_THR_LO: nxt_rd_data = thr_lo_ff;
      `ADDR_GAIN: nxt_rd_data = gain_ff;
      `ADDR_PWR1: nxt_rd_data = pwr1_ff;
      default: nxt_rd_data = `RST_ZERO;
    endcase
  end

  // read data captured once, so it stands for the whole data phase
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_ff <= `RST_ZERO;
    end else if (rd_req) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // serial pin retimed once more so the pin leaves a flop
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      miso_out <= `MISO_IDLE;
      miso_oen_out <= `MISO_OEN_OFF;
    end else begin
      miso_out <= miso_w;
      miso_oen_out <= miso_oen_w; // low while driving
    end
  end

  // outputs below are registered so they never glitch into the analog side
  // costs one mclk after each write, harmless for static settings
  // sixteen bit drop count
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sample_drop_interval_out <= `RST_WORD;
    end else begin
      sample_drop_interval_out <= {drop_hi_ff, drop_lo_ff};
    end
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      current_threshold_out <= `RST_WORD;
    end else begin
      current_threshold_out <= {thr_hi_ff, thr_lo_ff};
    end
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gain_current_out <= `RST_GAIN_CODE;
    end else begin
      gain_current_out <= gain_ff[`GAIN_I_HI:`GAIN_I_LO];
    end
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gain_voltage_out <= `RST_GAIN_CODE;
    end else begin
      gain_voltage_out <= gain_ff[`GAIN_V_HI:`GAIN_V_LO];
    end
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chop_clk_current_en_out <= `RST_EN_ON;
    end else begin
      chop_clk_current_en_out <= pwr1_ff[`PWR_CHOP_I];
    end
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chop_clk_voltage_en_out <= `RST_EN_ON;
    end else begin
      chop_clk_voltage_en_out <= pwr1_ff[`PWR_CHOP_V];
    end
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      amp_current_en_out <= `RST_EN_ON;
    end else begin
      amp_current_en_out <= pwr1_ff[`PWR_AMP_I];
    end
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mod_current_en_out <= `RST_EN_ON;
    end else begin
      mod_current_en_out <= pwr1_ff[`PWR_MOD_I];
    end
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      amp_voltage_en_out <= `RST_EN_ON;
    end else begin
      amp_voltage_en_out <= pwr1_ff[`PWR_AMP_V];
    end
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mod_voltage_en_out <= `RST_EN_ON;
    end else begin
      mod_voltage_en_out <= pwr1_ff[`PWR_MOD_V];
    end
  end
endmodule

// [rtl/frontend_regs_map.vh]
`ifndef FRONTEND_REGS_MAP_VH
`define FRONTEND_REGS_MAP_VH
`define ADDR_DROP_HI 7'h0f
`define ADDR_DROP_LO 7'h10
`define ADDR_THR_HI 7'h11
`define ADDR_THR_LO 7'h12
`define ADDR_GAIN 7'h13
`define ADDR_PWR1 7'h14
`define RST_ZERO 8'h00
`define RST_GAIN 8'h50
`define RST_PWR1 8'hcf
`define GAIN_WMASK 8'hf0
`define PWR1_WMASK 8'hcf
`define GAIN_I_HI 7
`define GAIN_I_LO 6
`define GAIN_V_HI 5
`define GAIN_V_LO 4
`define PWR_CHOP_I 7
`define PWR_CHOP_V 6
`define PWR_AMP_I 3
`define PWR_MOD_I 2
`define PWR_AMP_V 1
`define PWR_MOD_V 0
`define SPI_FRAME_BITS 16
`define SPI_CNT_W 5
`define SPI_CNT_ADDR 5'h07
`define SPI_CNT_LAST 5'h0f
`define SPI_CNT_RDLOAD 5'h08
`define SPI_FLAG_EARLY 6
`define SPI_FLAG_LATE 14
`define RST_WORD 16'h0000
`define RST_GAIN_CODE 2'h1
`define RST_EN_ON 1'b1
`define MISO_IDLE 1'b0
`define MISO_OEN_OFF 1'b1
`endif

// [rtl/spi_frame_shifter.v]
`timescale 1ns/1ps
`include "frontend_regs_map.vh"
// mode 0 spi slave, all pins oversampled on mclk
// frame: bit15 read flag (1=read), bits14:8 address, bits7:0 data msb first
module spi_frame_shifter (
  input wire mclk_in,
  input wire rstn_in,
  input wire sclk_in,
  input wire csn_in,
  input wire mosi_in,
  input wire [7:0] rd_data_in,
  output reg [6:0] addr_out,
  output reg rd_req_out,
  output reg wr_stb_out,
  output reg [7:0] wr_data_out,
  output reg miso_out,
  output reg miso_oen_out
);
  reg [1:0] sclk_s_ff;
  reg [1:0] csn_s_ff;
  reg [1:0] mosi_s_ff;
  reg sclk_d_ff;
  reg [15:0] shift_ff;
  reg [`SPI_CNT_W-1:0] cnt_ff;
  reg [7:0] rd_shift_ff;
  wire rise;
  wire fall;
  wire sel;
  // only the second stage of each synchroniser feeds logic
  assign rise = sclk_s_ff[1] & ~sclk_d_ff;
  assign fall = ~sclk_s_ff[1] & sclk_d_ff;
  assign sel = ~csn_s_ff[1];
  // synchronisers
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sclk_s_ff <= 2'h0;
      csn_s_ff <= 2'h3;
      mosi_s_ff <= 2'h0;
      sclk_d_ff <= 1'h0;
    end else begin
      sclk_s_ff <= {sclk_s_ff[0], sclk_in};
      csn_s_ff <= {csn_s_ff[0], csn_in};
      mosi_s_ff <= {mosi_s_ff[0], mosi_in};
      sclk_d_ff <= sclk_s_ff[1];
    end
  end
  // frame shifting and decode
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift_ff <= 16'h0000;
      cnt_ff <= 5'h00;
      rd_shift_ff <= 8'h00;
      addr_out <= 7'h00;
      rd_req_out <= 1'b0;
      wr_stb_out <= 1'b0;
      wr_data_out <= 8'h00;
      miso_out <= `MISO_IDLE;
      miso_oen_out <= `MISO_OEN_OFF;
    end else begin
      rd_req_out <= 1'b0;
      wr_stb_out <= 1'b0;
      miso_oen_out <= ~sel; // drive only while selected
      if (!sel) begin
        cnt_ff <= 5'h00;
      end else if (rise) begin
        shift_ff <= {shift_ff[14:0], mosi_s_ff[1]};
        cnt_ff <= cnt_ff + 5'h01;
        if (cnt_ff == `SPI_CNT_ADDR) begin
          // address known: fetch read data for the data phase
          addr_out <= {shift_ff[5:0], mosi_s_ff[1]};
          rd_req_out <= shift_ff[`SPI_FLAG_EARLY];
        end
        // last bit in: a write frame hands its byte over
        if (cnt_ff == `SPI_CNT_LAST && !shift_ff[`SPI_FLAG_LATE]) begin
          wr_data_out <= {shift_ff[6:0], mosi_s_ff[1]};
          wr_stb_out <= 1'b1;
        end
      end else if (fall) begin
        if (cnt_ff == `SPI_CNT_RDLOAD) begin
          miso_out <= rd_data_in[7];
          rd_shift_ff <= {rd_data_in[6:0], 1'b0};
        end else begin
          miso_out <= rd_shift_ff[7];
          rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
        end
      end
    end
  end
endmodule

// [tb/frontend_ctrl_regs_chk.sv]
`timescale 1ns/1ps
// register outputs must only move inside a frame and come up at reset values
module frontend_ctrl_regs_chk (
  input wire mclk_in,
  input wire rstn_in,
  input wire sclk_in,
  input wire csn_in,
  input wire mosi_in,
  input wire miso_out,
  input wire miso_oen_out,
  input wire [15:0] sample_drop_interval_out,
  input wire [15:0] current_threshold_out,
  input wire [1:0] gain_current_out,
  input wire [1:0] gain_voltage_out,
  input wire chop_clk_current_en_out,
  input wire chop_clk_voltage_en_out,
  input wire amp_current_en_out,
  input wire mod_current_en_out,
  input wire amp_voltage_en_out,
  input wire mod_voltage_en_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // the six enables side by side
  wire [5:0] pwr = {chop_clk_current_en_out, chop_clk_voltage_en_out, amp_current_en_out,
    mod_current_en_out, amp_voltage_en_out, mod_voltage_en_out};
  wire [3:0] gain = {gain_current_out, gain_voltage_out};
  a_drop_hold: assert property (csn_in && $past(csn_in) |->
      $stable(sample_drop_interval_out))
    else $error("drop count moved outside a frame");
  a_thr_hold: assert property (csn_in && $past(csn_in) |-> $stable(current_threshold_out))
    else $error("threshold moved outside a frame");
  a_gain_hold: assert property (csn_in && $past(csn_in) |-> $stable(gain))
    else $error("gain moved outside a frame");
  a_pwr_hold: assert property (csn_in && $past(csn_in) |-> $stable(pwr))
    else $error("enable moved outside a frame");
  a_rst_counts: assert property ($rose(rstn_in) |->
      (sample_drop_interval_out | current_threshold_out) == 16'h0000)
    else $error("count or threshold not zero after reset");
  a_rst_gain: assert property ($rose(rstn_in) |-> gain == 4'h5)
    else $error("gain not 01 after reset");
  a_rst_pwr: assert property ($rose(rstn_in) |-> pwr == 6'h3f)
    else $error("enables not set after reset");
  a_oen_idle: assert property (csn_in [*8] |-> miso_oen_out) // pin released when idle
    else $error("miso driven while deselected");
  a_oen_drive: assert property ((!csn_in) [*6] |-> !miso_oen_out) // pin driven in frame
    else $error("miso not driven while selected");
  cover property ($rose(csn_in));
  cover property ($changed(gain));
  cover property ($fell(amp_current_en_out));
  cover property (!csn_in && $rose(sclk_in) && mosi_in);
  cover property (!miso_oen_out && miso_out);
endmodule
bind frontend_ctrl_regs frontend_ctrl_regs_chk chk_u (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .sclk_in(sclk_in), .csn_in(csn_in), .mosi_in(mosi_in), .miso_out(miso_out),
  .miso_oen_out(miso_oen_out), .sample_drop_interval_out(sample_drop_interval_out),
  .current_threshold_out(current_threshold_out), .gain_current_out(gain_current_out),
  .gain_voltage_out(gain_voltage_out), .chop_clk_current_en_out(chop_clk_current_en_out),
  .chop_clk_voltage_en_out(chop_clk_voltage_en_out), .amp_current_en_out(amp_current_en_out),
  .mod_current_en_out(mod_current_en_out), .amp_voltage_en_out(amp_voltage_en_out),
  .mod_voltage_en_out(mod_voltage_en_out));

// [tb/frontend_ctrl_regs_tb_top.sv]
`timescale 1ns/1ps
// bench: serial host drives the bank, each task judges its own results
module frontend_ctrl_regs_tb_top;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  wire sclk_in, csn_in, mosi_in, miso_out, miso_oen_out;
  wire [15:0] drop, thr;
  wire [1:0] gi, gv;
  wire [5:0] pwr;
  int n_mismatch = 0;
  int compares = 0;
  logic [7:0] rdv;
  frontend_ctrl_regs dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .sclk_in(sclk_in),
    .csn_in(csn_in), .mosi_in(mosi_in), .miso_out(miso_out), .miso_oen_out(miso_oen_out),
    .sample_drop_interval_out(drop), .current_threshold_out(thr), .gain_current_out(gi),
    .gain_voltage_out(gv), .chop_clk_current_en_out(pwr[5]), .chop_clk_voltage_en_out(pwr[4]),
    .amp_current_en_out(pwr[3]), .mod_current_en_out(pwr[2]), .amp_voltage_en_out(pwr[1]),
    .mod_voltage_en_out(pwr[0]));
  spi_host_model host_u (.mclk_in(mclk_in), .sclk_out(sclk_in), .csn_out(csn_in),
    .mosi_out(mosi_in), .miso_in(miso_out));
  // 40 mhz clock
  always #12.5 mclk_in = ~mclk_in;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer({1'b0, a, d}, rdv);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host_u.xfer({1'b1, a, 8'h00}, rdv);
    chk({8'h00, rdv}, {8'h00, e});
  endtask
  task automatic t_reset;
    chk(drop | thr, 16'h0000);
    chk({10'h000, gi, gv, pwr}, 16'h017f);
    rd(7'h13, 8'h50);
    rd(7'h14, 8'hcf);
  endtask
  task automatic t_counts;
    wr(7'h0f, 8'ha5);
    wr(7'h10, 8'h5a);
    chk(drop, 16'ha55a);
    wr(7'h11, 8'h3c);
    wr(7'h12, 8'hc3);
    chk(thr, 16'h3cc3);
    rd(7'h0f, 8'ha5);
  endtask
  // every gain code on one channel, its inverse on the other
  task automatic t_gain;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(7'h13, {c, ~c, 4'hf});
      chk({12'h000, gi, gv}, {12'h000, c, ~c});
      rd(7'h13, {c, ~c, 4'h0});
    end
  endtask
  // walking one shows each enable high with the others low
  task automatic t_pwr;
    logic [7:0] v;
    for (int b = 0; b < 8; b++) begin
      v = 8'h01 << b;
      wr(7'h14, v);
      chk({10'h000, pwr}, {10'h000, v[7:6], v[3:0]});
      rd(7'h14, v & 8'hcf);
    end
  endtask
  task automatic t_unmapped;
    wr(7'h15, 8'hff);
    rd(7'h15, 8'h00);
    chk(drop, 16'ha55a);
  endtask
  // reset in mid-run puts every written field back to its reset value
  task automatic t_rerst;
    rstn_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(posedge mclk_in);
    chk(drop | thr, 16'h0000);
    chk({10'h000, gi, gv, pwr}, 16'h017f);
    rd(7'h13, 8'h50);
    rd(7'h0f, 8'h00);
  endtask
  task automatic test_done;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(posedge mclk_in);
    t_reset();
    t_counts();
    t_gain();
    t_pwr();
    t_unmapped();
    t_rerst();
    test_done();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge mclk_in);
    n_mismatch++;
    test_done();
  end
endmodule

// [tb/spi_host_model.sv]
`timescale 1ns/1ps
// mode 0 host; each sclk phase held 5 mclk to clear the synchronisers
module spi_host_model (
  input wire mclk_in,
  output logic sclk_out,
  output logic csn_out,
  output logic mosi_out,
  input wire miso_in
);
  initial begin
    sclk_out = 1'b0;
    csn_out = 1'b1;
    mosi_out = 1'b1;
  end
  // caller writes both bytes of a pair
  task automatic xfer(input logic [15:0] frm, output logic [7:0] rd);
    repeat (5) @(posedge mclk_in);
    csn_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out <= frm[i];
      repeat (5) @(posedge mclk_in);
      sclk_out <= 1'b1;
      repeat (5) @(posedge mclk_in);
      rd = {rd[6:0], miso_in}; // late in the high phase, miso long settled
      sclk_out <= 1'b0;
    end
    repeat (9) @(posedge mclk_in);
    csn_out <= 1'b1;
    mosi_out <= ~frm[0]; // no stale level between frames
  endtask
endmodule
